// File: rtl/tcam_engine.sv
/*
 * Table-driven electronic cam engine: master position tracking, table
 * lookup with interpolation, per-slave engage and disengage, register port.
 * Assumes master encoder and servo loops outside; master position delta
 * arrives from the main encoder port through a two-flop synchroniser.
 */
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module tcam_engine #(
   parameter int NSLAVE = 7,
   parameter int NPTS = 257
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [11:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic [3:0] enc_step,
   input wire logic enc_dir,
   output logic [NSLAVE*32-1:0] slave_cmd_pos,
   output logic [NSLAVE-1:0] slave_follow
);
   if (NSLAVE < 1 || NSLAVE > 7 || NPTS < 2 || NPTS > 257) begin : g_bad_params
      $error("tcam_engine: unsupported parameters");
   end

   // ==========================================================
   // Configuration registers
   logic [2:0] master_sel_reg;
   logic cam_enable_reg;
   logic [8:0] index_reg;
   logic [31:0] interval_reg;
   logic [31:0] offset_reg;
   logic [31:0] mcycle_reg;
   logic [31:0] cyccnt_reg;
   logic [2:0] axis_sel_reg;
   logic [31:0] schange_reg [NSLAVE];
   logic [31:0] eng_pos_reg [NSLAVE];
   logic [31:0] dis_pos_reg [NSLAVE];
   logic [NSLAVE-1:0] dis_pend_reg;
   logic signed [31:0] table_mem [NPTS];
   logic signed [31:0] spos_reg [NSLAVE];

   wire logic sel_ok = 32'(axis_sel_reg) < 32'(NSLAVE);
   wire logic tbl_hit = addr >= tcam_pkg::ADDR_TBL_BASE &&
      32'(addr - tcam_pkg::ADDR_TBL_BASE) < 32'(NPTS) * 32'd4;
   wire logic [8:0] tbl_idx = 9'((addr - tcam_pkg::ADDR_TBL_BASE) >> 2);

   always_ff @(posedge clk) begin
      if (!rstn) begin
         master_sel_reg <= 3'h0;
         axis_sel_reg <= 3'h0;
         cam_enable_reg <= 1'b0;
         interval_reg <= tcam_pkg::INTERVAL_RST;
         offset_reg <= 32'h0;
         mcycle_reg <= tcam_pkg::MCYCLE_RST;
      end else if (wr) begin
         unique case (addr)
            tcam_pkg::ADDR_MASTER_SEL: master_sel_reg <= wdata[2:0];
            tcam_pkg::ADDR_ENABLE: cam_enable_reg <= wdata[0];
            tcam_pkg::ADDR_INTERVAL: interval_reg <= (wdata == 32'h0) ? 32'h1 : wdata;
            tcam_pkg::ADDR_OFFSET: offset_reg <= wdata;
            tcam_pkg::ADDR_MCYCLE: begin
               mcycle_reg <= (wdata > tcam_pkg::MCYCLE_MAX) ? tcam_pkg::MCYCLE_MAX : wdata;
            end
            tcam_pkg::ADDR_AXIS_SEL: axis_sel_reg <= wdata[2:0];
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (wr && tbl_hit) begin
         table_mem[tbl_idx] <= wdata;
      end
   end

   // ==========================================================
   // Master encoder synchroniser and modulo position
   logic [3:0] step_s1_reg;
   logic [3:0] step_s2_reg;
   logic dir_s1_reg;
   logic dir_s2_reg;
   logic [31:0] mpos_reg;
   logic wrap_fwd;
   logic wrap_rev;
   logic [31:0] mpos_next;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         step_s1_reg <= 4'h0;
         step_s2_reg <= 4'h0;
         dir_s1_reg <= 1'b0;
         dir_s2_reg <= 1'b0;
      end else begin
         step_s1_reg <= enc_step;
         step_s2_reg <= step_s1_reg;
         dir_s1_reg <= enc_dir;
         dir_s2_reg <= dir_s1_reg;
      end
   end

   always_comb begin
      wrap_fwd = 1'b0;
      wrap_rev = 1'b0;
      if (!dir_s2_reg) begin
         mpos_next = mpos_reg + 32'(step_s2_reg);
         if (mcycle_reg != 32'h0 && mpos_next >= mcycle_reg) begin
            mpos_next = mpos_next - mcycle_reg;
            wrap_fwd = 1'b1;
         end
      end else begin
         mpos_next = mpos_reg - 32'(step_s2_reg);
         if (mcycle_reg != 32'h0 && 32'(step_s2_reg) > mpos_reg) begin
            mpos_next = mpos_next + mcycle_reg;
            wrap_rev = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn || !cam_enable_reg) begin
         mpos_reg <= 32'h0;
      end else begin
         mpos_reg <= mpos_next;
      end
   end

   // Position p is met this cycle: standing on it or passed over by a multi-count step
   function automatic logic pos_reached(input logic [31:0] p, input logic [31:0] cur, input logic [31:0] nxt,
      input logic rev, input logic wrapped);
      logic hit;
      hit = (p == cur);
      if (!rev && !wrapped) begin
         hit = hit || (p > cur && p <= nxt);
      end else if (!rev) begin
         hit = hit || p > cur || p <= nxt;
      end else if (!wrapped) begin
         hit = hit || (p < cur && p >= nxt);
      end else begin
         hit = hit || p < cur || p >= nxt;
      end
      return hit;
   endfunction

   always_ff @(posedge clk) begin
      if (!rstn) begin
         cyccnt_reg <= 32'h0;
      end else if (wr && addr == tcam_pkg::ADDR_CYCCNT) begin
         cyccnt_reg <= wdata;
      end else if (cam_enable_reg && wrap_fwd) begin
         cyccnt_reg <= cyccnt_reg + 32'h1;
      end else if (cam_enable_reg && wrap_rev) begin
         cyccnt_reg <= cyccnt_reg - 32'h1;
      end
   end

   // ==========================================================
   // Table index and interpolation
   logic [31:0] rel_pos;
   logic [31:0] seg_frac;
   logic [8:0] seg_idx;
   logic [31:0] seg_full;
   logic signed [31:0] pt_lo;
   logic signed [31:0] pt_hi;
   logic signed [63:0] interp_prod;
   logic signed [31:0] interp_pos;

   always_comb begin
      rel_pos = mpos_reg - offset_reg;
      // Clamp before narrowing so far positions do not wrap into the table
      seg_full = rel_pos / interval_reg;
      if (seg_full >= 32'(NPTS - 1)) begin
         seg_full = 32'(NPTS - 2);
      end
      seg_idx = seg_full[8:0];
      seg_frac = rel_pos - 32'(seg_idx) * interval_reg;
      pt_lo = table_mem[seg_idx];
      pt_hi = table_mem[9'(seg_idx + 9'h1)];
      interp_prod = 64'(pt_hi - pt_lo) * $signed({32'h0, seg_frac});
      interp_pos = pt_lo + 32'(interp_prod / $signed({32'h0, interval_reg}));
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         index_reg <= 9'h0;
      end else if (wr && addr == tcam_pkg::ADDR_INDEX) begin
         index_reg <= wdata[8:0];
      end else if (cam_enable_reg) begin
         index_reg <= seg_idx;
      end
   end

   // ==========================================================
   // Per-slave engage, disengage and position
   logic [NSLAVE-1:0] engaged_reg;
   logic [NSLAVE-1:0] armed_reg;

   genvar g;
   generate
      for (g = 0; g < NSLAVE; g++) begin : g_slave
         wire logic hit_sel = wr && sel_ok && axis_sel_reg == 3'(g);
         wire logic eng_wr = hit_sel && addr == tcam_pkg::ADDR_ENGAGE;
         wire logic dis_wr = hit_sel && addr == tcam_pkg::ADDR_DISENGAGE;
         wire logic eng_hit = pos_reached(eng_pos_reg[g], mpos_reg, mpos_next, dir_s2_reg, wrap_fwd || wrap_rev);
         wire logic dis_hit = pos_reached(dis_pos_reg[g], mpos_reg, mpos_next, dir_s2_reg, wrap_fwd || wrap_rev);
         logic [31:0] sch_mod;

         always_comb begin
            sch_mod = (schange_reg[g] == 32'h0) ? 32'h0 : 32'($unsigned(spos_reg[g]) % schange_reg[g]);
         end

         always_ff @(posedge clk) begin
            if (!rstn) begin
               schange_reg[g] <= 32'h0;
               eng_pos_reg[g] <= 32'h0;
               dis_pos_reg[g] <= 32'h0;
            end else begin
               if (hit_sel && addr == tcam_pkg::ADDR_SCHANGE) begin
                  // Magnitude only; direction comes from the table itself
                  schange_reg[g] <= (wdata > tcam_pkg::SCHANGE_MAX) ? tcam_pkg::SCHANGE_MAX : wdata;
               end
               if (eng_wr) begin
                  eng_pos_reg[g] <= wdata;
               end
               if (dis_wr) begin
                  dis_pos_reg[g] <= wdata;
               end
            end
         end

         always_ff @(posedge clk) begin
            if (!rstn || !cam_enable_reg) begin
               engaged_reg[g] <= 1'b0;
               armed_reg[g] <= 1'b0;
               dis_pend_reg[g] <= 1'b0;
            end else if (eng_wr) begin
               if (wdata >= mcycle_reg) begin
                  engaged_reg[g] <= 1'b1;
                  armed_reg[g] <= 1'b0;
               end else begin
                  armed_reg[g] <= 1'b1;
               end
               dis_pend_reg[g] <= 1'b0;
            end else if (dis_wr) begin
               if (wdata >= mcycle_reg) begin
                  engaged_reg[g] <= 1'b0;
                  armed_reg[g] <= 1'b0;
                  dis_pend_reg[g] <= 1'b0;
               end else begin
                  dis_pend_reg[g] <= 1'b1;
               end
            end else if (armed_reg[g] && eng_hit) begin
               engaged_reg[g] <= 1'b1;
               armed_reg[g] <= 1'b0;
            end else if (dis_pend_reg[g] && engaged_reg[g] && dis_hit) begin
               engaged_reg[g] <= 1'b0;
               dis_pend_reg[g] <= 1'b0;
            end
         end

         always_ff @(posedge clk) begin
            if (!rstn) begin
               spos_reg[g] <= 32'sh0;
            end else if (wr && sel_ok && axis_sel_reg == 3'(g) && addr == tcam_pkg::ADDR_SPOS) begin
               spos_reg[g] <= wdata;
            end else if (eng_wr || (armed_reg[g] && eng_hit)) begin
               spos_reg[g] <= sch_mod;
            end else if (engaged_reg[g] && wrap_fwd) begin
               spos_reg[g] <= 32'sh0;
            end else if (engaged_reg[g]) begin
               spos_reg[g] <= interp_pos;
            end
         end

         always_ff @(posedge clk) begin
            if (!rstn) begin
               slave_cmd_pos[g*32 +: 32] <= 32'h0;
               slave_follow[g] <= 1'b0;
            end else begin
               slave_cmd_pos[g*32 +: 32] <= spos_reg[g];
               slave_follow[g] <= engaged_reg[g];
            end
         end
      end
   endgenerate

   // ==========================================================
   // Read port
   logic [31:0] rd_mux;

   always_comb begin
      rd_mux = tcam_pkg::UNMAPPED_DATA;
      if (tbl_hit) begin
         rd_mux = table_mem[tbl_idx];
      end else begin
         unique case (addr)
            tcam_pkg::ADDR_MASTER_SEL: rd_mux = 32'(master_sel_reg);
            tcam_pkg::ADDR_ENABLE: rd_mux = 32'(cam_enable_reg);
            tcam_pkg::ADDR_INDEX: rd_mux = 32'(index_reg);
            tcam_pkg::ADDR_INTERVAL: rd_mux = interval_reg;
            tcam_pkg::ADDR_OFFSET: rd_mux = offset_reg;
            tcam_pkg::ADDR_MCYCLE: rd_mux = mcycle_reg;
            tcam_pkg::ADDR_CYCCNT: rd_mux = cyccnt_reg;
            tcam_pkg::ADDR_ENG_STAT: rd_mux = 32'(engaged_reg);
            tcam_pkg::ADDR_DIS_STAT: rd_mux = 32'(dis_pend_reg);
            tcam_pkg::ADDR_MPOS: rd_mux = mpos_reg;
            tcam_pkg::ADDR_AXIS_SEL: rd_mux = 32'(axis_sel_reg);
            tcam_pkg::ADDR_SCHANGE: rd_mux = sel_ok ? schange_reg[axis_sel_reg] : 32'h0;
            tcam_pkg::ADDR_ENGAGE: rd_mux = sel_ok ? eng_pos_reg[axis_sel_reg] : 32'h0;
            tcam_pkg::ADDR_DISENGAGE: rd_mux = sel_ok ? dis_pos_reg[axis_sel_reg] : 32'h0;
            tcam_pkg::ADDR_SPOS: rd_mux = sel_ok ? spos_reg[axis_sel_reg] : 32'h0;
            default: rd_mux = tcam_pkg::UNMAPPED_DATA;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         rdata <= 32'h0;
      end else if (rd) begin
         rdata <= rd_mux;
      end else begin
         rdata <= 32'h0;
      end
   end
endmodule

// File: inc/tcam_pkg.sv
/*
 * Constants, state encodings and the register map of the table-driven
 * electronic cam engine.
 * Assumes a single 20 MHz clock and a plain strobe-based register port.
 */
// Summary of operation
// - The main encoder port drives up to seven slave axes together; the master select is only stored.
// - In cam mode the master position is kept between zero and cycle length.
// - At cycle end master and slave positions both return to zero.
// - Master cycle at most 8388607 counts, slave change at most 2147483647.
// - Table indexed at uniform master intervals with size and offset, 256 intervals.
// - Entries addressed zero to 256, each holding the slave position at that point.
// - Enable command switches cam mode on; slaves follow only after engage.
// - Engage position outside one cycle engages that slave at once.
// - On engage the slave position is redefined modulo its per-cycle change.
// - Disengage releases each named slave when master reaches its given position.
// - Disengage position outside the cycle stops that slave at once.
// - Host sets the current table index; index and interval are readable.
// - Enable state, per-axis engage and disengage status and cycle sizes readable.
// - A cam cycle count is kept that host can set and read.
package tcam_pkg;
   // ==========================================================
   // Register offsets (word index = byte offset / 4)
   localparam logic [11:0] ADDR_MASTER_SEL = 12'h000;
   localparam logic [11:0] ADDR_ENABLE = 12'h004;
   localparam logic [11:0] ADDR_INDEX = 12'h008;
   localparam logic [11:0] ADDR_INTERVAL = 12'h00c;
   localparam logic [11:0] ADDR_OFFSET = 12'h010;
   localparam logic [11:0] ADDR_MCYCLE = 12'h014;
   localparam logic [11:0] ADDR_CYCCNT = 12'h018;
   localparam logic [11:0] ADDR_ENG_STAT = 12'h01c;
   localparam logic [11:0] ADDR_DIS_STAT = 12'h020;
   localparam logic [11:0] ADDR_MPOS = 12'h024;
   localparam logic [11:0] ADDR_AXIS_SEL = 12'h028;
   localparam logic [11:0] ADDR_SCHANGE = 12'h02c;
   localparam logic [11:0] ADDR_ENGAGE = 12'h030;
   localparam logic [11:0] ADDR_DISENGAGE = 12'h034;
   localparam logic [11:0] ADDR_SPOS = 12'h038;
   localparam logic [11:0] ADDR_TBL_BASE = 12'h400;
   // ==========================================================
   // Limits and reset values
   localparam logic [31:0] MCYCLE_MAX = 32'h007f_ffff;
   localparam logic [31:0] SCHANGE_MAX = 32'h7fff_ffff;
   localparam logic [31:0] MCYCLE_RST = 32'h0000_0000;
   localparam logic [31:0] INTERVAL_RST = 32'h0000_0001;
   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
   // ==========================================================
   // Per-slave state
   typedef enum logic [2:0] {
      TCAM_IDLE = 3'b001,
      TCAM_ARMED = 3'b010,
      TCAM_RUN = 3'b100
   } tcam_slave_e;
endpackage

// File: dv/tcam_enc_model.sv
/* Master encoder model: pulses counts into the main encoder port.
   Assumes the bench calls move() from just after a clock edge. */
`timescale 1ns/1ps
module tcam_enc_model (
   input wire logic clk,
   output logic [3:0] enc_step,
   output logic enc_dir
);
   initial begin
      enc_step = 4'h0;
      enc_dir = 1'b0;
   end
   // Total n counts at s counts per cycle; s=1 is slow, larger is prompt
   task automatic move(input int n, input int s, input logic d);
      for (int i = 0; i < n / s; i++) begin
         @(posedge clk);
         enc_step <= 4'(s);
         enc_dir <= d;
      end
      @(posedge clk);
      enc_step <= 4'h0;
      // Lets the synchroniser and the position register settle
      repeat (3) @(posedge clk);
   endtask
endmodule

// File: dv/tcam_engine_checker.sv
/* Port-level checks of the cam engine.
   Assumes host writes and reads follow the strobe register port. */
`timescale 1ns/1ps
module tcam_engine_checker #(
   parameter int NSLAVE = 7
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [11:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [31:0] rdata,
   input wire logic [3:0] enc_step,
   input wire logic enc_dir,
   input wire logic [NSLAVE*32-1:0] slave_cmd_pos,
   input wire logic [NSLAVE-1:0] slave_follow
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // ==========
   // Host-side shadows
   logic en_q;
   logic [31:0] mc_q;
   logic [3:0] off_cnt;
   always_ff @(posedge clk) begin
      if (!rstn) en_q <= 1'b0;
      else if (wr && addr == tcam_pkg::ADDR_ENABLE) en_q <= wdata[0];
   end
   always_ff @(posedge clk) begin
      if (!rstn) mc_q <= '0;
      else if (wr && addr == tcam_pkg::ADDR_MCYCLE)
         mc_q <= (wdata > tcam_pkg::MCYCLE_MAX) ? tcam_pkg::MCYCLE_MAX : wdata;
   end
   always_ff @(posedge clk) begin
      if (!rstn || en_q) off_cnt <= 4'h0;
      else if (off_cnt != 4'hf) off_cnt <= off_cnt + 4'h1;
   end
   // ==========
   // Assertions
   AST_MCYCLE_CLAMP: assert property (wr && addr == tcam_pkg::ADDR_MCYCLE && wdata > tcam_pkg::MCYCLE_MAX
      ##2 rd && addr == tcam_pkg::ADDR_MCYCLE |=> rdata == tcam_pkg::MCYCLE_MAX) else $error("cycle not clamped");
   AST_INTERVAL_ZERO: assert property (wr && addr == tcam_pkg::ADDR_INTERVAL && wdata == '0
      ##2 rd && addr == tcam_pkg::ADDR_INTERVAL |=> rdata == 32'h1) else $error("zero interval kept");
   AST_INTERVAL_BACK: assert property (wr && addr == tcam_pkg::ADDR_INTERVAL && wdata != '0
      ##2 rd && addr == tcam_pkg::ADDR_INTERVAL |=> rdata == $past(wdata, 3)) else $error("interval readback");
   AST_ENABLE_BACK: assert property (wr && addr == tcam_pkg::ADDR_ENABLE
      ##2 rd && addr == tcam_pkg::ADDR_ENABLE |=> rdata[0] == $past(wdata[0], 3)) else $error("enable readback");
   AST_CYCCNT_BACK: assert property (wr && addr == tcam_pkg::ADDR_CYCCNT
      ##2 rd && addr == tcam_pkg::ADDR_CYCCNT |=> rdata == $past(wdata, 3)) else $error("cycle count readback");
   AST_MPOS_RANGE: assert property (en_q && mc_q != '0 && rd && addr == tcam_pkg::ADDR_MPOS
      |=> rdata < mc_q) else $error("master position outside cycle");
   AST_OFF_NO_FOLLOW: assert property (off_cnt > 4'h3 |-> slave_follow == '0)
      else $error("slave follows with cam off");
   AST_FOLLOW_NEEDS_EN: assert property ($rose(|slave_follow) |-> en_q)
      else $error("follow without enable");
   AST_UNMAPPED_ZERO: assert property (rd && addr == 12'h03c |=> rdata == '0)
      else $error("unmapped read not zero");
   cover property ($rose(slave_follow[0]));
   cover property ($fell(slave_follow[0]));
   cover property (en_q && rd && addr == tcam_pkg::ADDR_MPOS);
   cover property (enc_step != 4'h0 && enc_dir && slave_follow[0]);
endmodule
bind tcam_engine tcam_engine_checker #(.NSLAVE(NSLAVE)) u_tcam_engine_checker (.clk(clk), .rstn(rstn),
   .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .enc_step(enc_step), .enc_dir(enc_dir),
   .slave_cmd_pos(slave_cmd_pos), .slave_follow(slave_follow));

// File: dv/tcam_engine_bench.sv
/* Self-checking bench of the cam engine with an encoder model.
   Assumes a 20 MHz clock and register reads answered one cycle later. */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin failures++; \
   $display("Error %s expected %h seen %h", nm, ex, got); end end
module tcam_engine_bench;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [11:0] addr = 12'h000;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic rd_d = 1'b0;
   logic [31:0] rdata;
   logic [3:0] enc_step;
   logic enc_dir;
   logic [223:0] slave_cmd_pos;
   logic [6:0] slave_follow;
   logic [31:0] exp_q[$];
   string name_q[$];
   int failures = 0;
   int checks_done = 0;
   logic [31:0] v = 32'h31;
   logic [31:0] cc;
   logic [31:0] mon_exp;
   string mon_name;
   always #25 clk = ~clk;
   tcam_engine #(.NSLAVE(7), .NPTS(257)) u_tcam_engine (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .enc_step(enc_step), .enc_dir(enc_dir), .slave_cmd_pos(slave_cmd_pos),
      .slave_follow(slave_follow));
   tcam_enc_model u_tcam_enc_model (.clk(clk), .enc_step(enc_step), .enc_dir(enc_dir));
   // ==========
   // Driver tasks
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task automatic rnd();
      v = xorshift(v);
   endtask
   task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [11:0] a, input logic [31:0] e, input string nm);
      @(posedge clk);
      exp_q.push_back(e);
      name_q.push_back(nm);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
   endtask
   task automatic chk_follow(input int n, input logic e);
      repeat (n) @(posedge clk);
      @(negedge clk);
      `CHK("slave_follow", e, slave_follow[0])
   endtask
   task automatic summarize();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // ==========
   // Read monitor
   always @(posedge clk) rd_d <= rd;
   always @(negedge clk) begin
      if (rd_d) begin
         mon_exp = exp_q.pop_front();
         mon_name = name_q.pop_front();
         `CHK(mon_name, mon_exp, rdata)
      end
   end
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      summarize();
   end
   // ==========
   // Scenarios
   initial begin
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      rd_reg(tcam_pkg::ADDR_ENABLE, 32'h0, "enable");
      rd_reg(tcam_pkg::ADDR_INTERVAL, 32'h1, "interval");
      rd_reg(12'h03c, 32'h0, "unmapped");
      wr_reg(tcam_pkg::ADDR_INTERVAL, 32'h0);
      rd_reg(tcam_pkg::ADDR_INTERVAL, 32'h1, "interval");
      wr_reg(tcam_pkg::ADDR_MCYCLE, 32'hffff_ffff);
      rd_reg(tcam_pkg::ADDR_MCYCLE, tcam_pkg::MCYCLE_MAX, "cycle");
      for (int g = 0; g < 8; g++) begin
         rnd();
         wr_reg(tcam_pkg::ADDR_AXIS_SEL, 32'(g));
         wr_reg(tcam_pkg::ADDR_SCHANGE, {1'b0, v[30:0]});
         rd_reg(tcam_pkg::ADDR_SCHANGE, (g < 7) ? {1'b0, v[30:0]} : 32'h0, "axis cycle");
      end
      wr_reg(tcam_pkg::ADDR_AXIS_SEL, 32'h0);
      wr_reg(tcam_pkg::ADDR_SCHANGE, 32'hffff_ffff);
      rd_reg(tcam_pkg::ADDR_SCHANGE, tcam_pkg::SCHANGE_MAX, "change");
      for (int n = 0; n < 257; n += 256) begin
         rnd();
         wr_reg(tcam_pkg::ADDR_TBL_BASE + 12'(n * 4), v);
         rd_reg(tcam_pkg::ADDR_TBL_BASE + 12'(n * 4), v, "entry");
      end
      rnd();
      cc = v;
      wr_reg(tcam_pkg::ADDR_CYCCNT, cc);
      rd_reg(tcam_pkg::ADDR_CYCCNT, cc, "cycle count");
      wr_reg(tcam_pkg::ADDR_INDEX, 32'h5);
      rd_reg(tcam_pkg::ADDR_INDEX, 32'h5, "index");
      wr_reg(tcam_pkg::ADDR_MCYCLE, 32'h28);
      wr_reg(tcam_pkg::ADDR_INTERVAL, 32'ha);
      rd_reg(tcam_pkg::ADDR_INTERVAL, 32'ha, "interval");
      wr_reg(tcam_pkg::ADDR_OFFSET, 32'h0);
      wr_reg(tcam_pkg::ADDR_SCHANGE, 32'h190);
      for (int n = 0; n < 5; n++) wr_reg(tcam_pkg::ADDR_TBL_BASE + 12'(n * 4), 32'(n * 100));
      wr_reg(tcam_pkg::ADDR_ENABLE, 32'h1);
      rd_reg(tcam_pkg::ADDR_ENABLE, 32'h1, "enable");
      chk_follow(10, 1'b0);
      wr_reg(tcam_pkg::ADDR_ENGAGE, 32'h28);
      chk_follow(10, 1'b1);
      rd_reg(tcam_pkg::ADDR_ENG_STAT, 32'h1, "engaged");
      u_tcam_enc_model.move(15, 5, 1'b0);
      rd_reg(tcam_pkg::ADDR_MPOS, 32'hf, "master pos");
      `CHK("slave pos", 32'h96, slave_cmd_pos[31:0])
      u_tcam_enc_model.move(30, 1, 1'b0);
      rd_reg(tcam_pkg::ADDR_MPOS, 32'h5, "master pos");
      `CHK("slave pos", 32'h32, slave_cmd_pos[31:0])
      rd_reg(tcam_pkg::ADDR_CYCCNT, cc + 32'h1, "cycle count");
      wr_reg(tcam_pkg::ADDR_DISENGAGE, 32'h28);
      chk_follow(10, 1'b0);
      wr_reg(tcam_pkg::ADDR_ENGAGE, 32'h14);
      chk_follow(10, 1'b0);
      u_tcam_enc_model.move(20, 2, 1'b0);
      chk_follow(10, 1'b1);
      u_tcam_enc_model.move(3, 1, 1'b1);
      chk_follow(10, 1'b1);
      `CHK("slave pos", 32'hdc, slave_cmd_pos[31:0])
      wr_reg(tcam_pkg::ADDR_DISENGAGE, 32'h1e);
      rd_reg(tcam_pkg::ADDR_DIS_STAT, 32'h1, "disengage pending");
      u_tcam_enc_model.move(10, 1, 1'b0);
      chk_follow(10, 1'b0);
      wr_reg(tcam_pkg::ADDR_ENGAGE, 32'h28);
      chk_follow(10, 1'b1);
      wr_reg(tcam_pkg::ADDR_AXIS_SEL, 32'h6);
      wr_reg(tcam_pkg::ADDR_ENGAGE, 32'h28);
      chk_follow(10, 1'b1);
      `CHK("slave follow", 7'h41, slave_follow)
      `CHK("slave pos", 32'h140, slave_cmd_pos[223:192])
      `CHK("slave pos", 32'h140, slave_cmd_pos[31:0])
      `CHK("idle slaves", 160'h0, slave_cmd_pos[191:32])
      wr_reg(tcam_pkg::ADDR_ENABLE, 32'h0);
      chk_follow(10, 1'b0);
      `CHK("slave follow", 7'h00, slave_follow)
      rd_reg(tcam_pkg::ADDR_MPOS, 32'h0, "master pos");
      repeat (3) @(posedge clk);
      summarize();
   end
endmodule
